// ### verilog/ocad_map.vh
// constants for the on-screen-display character attribute decoder
// assumes: included by bare name from every ocad design file
//
// Behaviour
// - caption and general modes: font code joins nine low bits, one high
// - caption mode: three-bit foreground palette index
// - general modes: four-bit foreground, msb in italic field
// - general modes: background bits from effect fields, colour 2
// - caption mode: two-bit background from colour code 2
// - caption mode: italic, flash, underline, one enables
// - every mode: per-character bit gates aux video
// - colour-dot: palette-0 dots take per-character palette
// - colour code 2 bits 3..7 read undefined
// - unused entry bits still store and read back
// - caption palette range bit picks 0-7 or 8-15
// - palette 0 transparent, palette 8 black
`ifndef OCAD_MAP_VH
`define OCAD_MAP_VH

// display modes
`define OCAD_MODE_CC      2'h0
`define OCAD_MODE_GEN     2'h1
`define OCAD_MODE_CD      2'h2
`define OCAD_MODE_GEN_ALT 2'h3

// entry field selects on the cpu port
`define OCAD_SEL_CODE     2'h0
`define OCAD_SEL_COL1     2'h1
`define OCAD_SEL_COL2     2'h2

// storage geometry
`define OCAD_DEPTH        128
`define OCAD_AW           7
`define OCAD_CODE_W       9
`define OCAD_COL1_W       8
`define OCAD_COL2_W       3

// colour code 1 bit positions
`define OCAD_C1_FG0       1
`define OCAD_C1_FG1       2
`define OCAD_C1_FG2       3
`define OCAD_C1_ITAL      4
`define OCAD_C1_FLASH     5
`define OCAD_C1_ULINE     6
`define OCAD_C1_AUX       7

// colour code 2 bit positions
`define OCAD_C2_BG0       0
`define OCAD_C2_BG1       1
`define OCAD_C2_FONTHI    2

// colour-dot code width and palette codes
`define OCAD_CD_CODE_W    7
`define OCAD_PAL_TRANSP   4'h0
`define OCAD_PAL_BLACK    4'h8

// reset values
`define OCAD_RST_CODE     9'h000
`define OCAD_RST_COL1     8'h00
`define OCAD_RST_COL2     3'h0
`define OCAD_RST_FONT     10'h000

`endif

// ### verilog/ocad_field_map.v
// field unpacking of one display entry into its decoded meanings
// assumes: purely combinational; the caller registers every output
`timescale 1ns/1ps
`include "ocad_map.vh"

module ocad_field_map (
    // stored entry
    input  wire [`OCAD_CODE_W-1:0] code_i,
    input  wire [`OCAD_COL1_W-1:0] col1_i,
    input  wire [`OCAD_COL2_W-1:0] col2_i,
    // configuration
    input  wire [1:0]              mode_i,
    input  wire                    cc_range_hi_i,
    // decoded fields
    output reg  [9:0]              font_code_o,
    output reg  [3:0]              fg_palette_o,
    output reg  [3:0]              bg_palette_o,
    output reg                     italic_o,
    output reg                     flash_o,
    output reg                     underline_o,
    output wire                    aux_video_gate_o,
    output wire [3:0]              dot_palette_o
);

    ////////////////////////////////////////////////////////////////////////
    // field aliases
    wire fg_palette_bit0       = col1_i[`OCAD_C1_FG0];
    wire fg_palette_bit1       = col1_i[`OCAD_C1_FG1];
    wire fg_palette_bit2_field = col1_i[`OCAD_C1_FG2];
    wire italic_or_fg_bit3     = col1_i[`OCAD_C1_ITAL];
    wire flash_or_bg_bit0      = col1_i[`OCAD_C1_FLASH];
    wire underline_or_bg_bit1  = col1_i[`OCAD_C1_ULINE];
    wire font_code_high_bit    = col2_i[`OCAD_C2_FONTHI];

    // the gate bit means the same in every mode
    assign aux_video_gate_o = col1_i[`OCAD_C1_AUX];

    // per-character dot palette spans the upper colour-1 bits
    assign dot_palette_o = {underline_or_bg_bit1, flash_or_bg_bit0,
                            italic_or_fg_bit3, fg_palette_bit2_field};

    ////////////////////////////////////////////////////////////////////////
    // mode-dependent meaning
    always @* begin
        font_code_o  = {font_code_high_bit, code_i};
        fg_palette_o = {italic_or_fg_bit3, fg_palette_bit2_field,
                        fg_palette_bit1, fg_palette_bit0};
        bg_palette_o = {col2_i[`OCAD_C2_BG1], col2_i[`OCAD_C2_BG0],
                        underline_or_bg_bit1, flash_or_bg_bit0};
        italic_o     = 1'b0;
        flash_o      = 1'b0;
        underline_o  = 1'b0;
        case (mode_i)
            `OCAD_MODE_CC: begin
                // range bit steers the 3-bit index into the upper bank
                fg_palette_o = {cc_range_hi_i, fg_palette_bit2_field,
                                fg_palette_bit1, fg_palette_bit0};
                bg_palette_o = {2'h0, col2_i[`OCAD_C2_BG1],
                                col2_i[`OCAD_C2_BG0]};
                italic_o     = italic_or_fg_bit3;
                flash_o      = flash_or_bg_bit0;
                underline_o  = underline_or_bg_bit1;
            end
            `OCAD_MODE_CD: begin
                // only the low code bits name a colour-dot font
                font_code_o  = {3'h0, code_i[`OCAD_CD_CODE_W-1:0]};
                fg_palette_o = `OCAD_PAL_TRANSP;
                bg_palette_o = `OCAD_PAL_TRANSP;
            end
            default: begin
                // general display modes keep the defaults above
                font_code_o  = {font_code_high_bit, code_i};
            end
        endcase
    end

endmodule // ocad_field_map

// ### verilog/ocad_char_decode.v
// on-screen-display character entry store and attribute decoder
// assumes: cpu and display engine run on ref_clk_i; all control
// inputs come from logic in the same clock domain
`timescale 1ns/1ps
`include "ocad_map.vh"

module ocad_char_decode (
    // clock and reset
    input  wire                    ref_clk_i,
    input  wire                    rstn_i,
    // configuration
    input  wire [1:0]              mode_i,
    input  wire                    cc_range_hi_i,
    // cpu access to the entry memory
    input  wire                    cpu_wr_i,
    input  wire                    cpu_rd_i,
    input  wire [`OCAD_AW-1:0]     cpu_addr_i,
    input  wire [1:0]              cpu_sel_i,
    input  wire [`OCAD_CODE_W-1:0] cpu_wdata_i,
    output reg  [`OCAD_CODE_W-1:0] cpu_rdata_o,
    output reg                     cpu_rvalid_o,
    // display engine entry fetch
    input  wire                    disp_req_i,
    input  wire [`OCAD_AW-1:0]     disp_addr_i,
    output reg                     disp_valid_o,
    output reg  [9:0]              font_code_o,
    output reg  [3:0]              fg_palette_o,
    output reg  [3:0]              bg_palette_o,
    output reg                     italic_o,
    output reg                     flash_o,
    output reg                     underline_o,
    output reg                     aux_video_output_o,
    output reg                     fg_transparent_o,
    output reg                     fg_black_o,
    output reg                     bg_transparent_o,
    output reg                     bg_black_o,
    // font dot colour resolution
    input  wire                    dot_req_i,
    input  wire [3:0]              dot_palette_i,
    output reg                     dot_valid_o,
    output reg  [3:0]              dot_colour_o,
    output reg                     dot_transparent_o,
    output reg                     dot_black_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // fixed palettes: 0 transparent, 8 black, the rest programmable
    function is_transp;
        input [3:0] pal;
        begin
            is_transp = (pal == `OCAD_PAL_TRANSP);
        end
    endfunction

    function is_black;
        input [3:0] pal;
        begin
            is_black = (pal == `OCAD_PAL_BLACK);
        end
    endfunction

    // modes 1 and 3 both act as the general display modes
    function is_cd_mode;
        input [1:0] m;
        begin
            is_cd_mode = (m == `OCAD_MODE_CD);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // entry storage
    // three narrow arrays rather than one wide word, so a cpu write to
    // one field never disturbs the other two

    reg [`OCAD_CODE_W-1:0] code_mem [0:`OCAD_DEPTH-1];
    reg [`OCAD_COL1_W-1:0] col1_mem [0:`OCAD_DEPTH-1];
    reg [`OCAD_COL2_W-1:0] col2_mem [0:`OCAD_DEPTH-1];

    integer i;

    // cpu writes store every bit, whether or not the mode uses it
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < `OCAD_DEPTH; i = i + 1) begin
                code_mem[i] <= `OCAD_RST_CODE;
                col1_mem[i] <= `OCAD_RST_COL1;
                col2_mem[i] <= `OCAD_RST_COL2;
            end
        end else if (cpu_wr_i) begin
            case (cpu_sel_i)
                `OCAD_SEL_CODE: begin
                    code_mem[cpu_addr_i] <= cpu_wdata_i;
                end
                `OCAD_SEL_COL1: begin
                    col1_mem[cpu_addr_i] <= cpu_wdata_i[`OCAD_COL1_W-1:0];
                end
                `OCAD_SEL_COL2: begin
                    // bits 3..7 have no storage behind them
                    col2_mem[cpu_addr_i] <= cpu_wdata_i[`OCAD_COL2_W-1:0];
                end
                default: begin
                    code_mem[cpu_addr_i] <= code_mem[cpu_addr_i];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu read-back
    // read returns the contents before any write in the same cycle

    reg [`OCAD_CODE_W-1:0] cpu_rdata_d;

    always @* begin
        case (cpu_sel_i)
            `OCAD_SEL_CODE: begin
                cpu_rdata_d = code_mem[cpu_addr_i];
            end
            `OCAD_SEL_COL1: begin
                cpu_rdata_d = {1'b0, col1_mem[cpu_addr_i]};
            end
            `OCAD_SEL_COL2: begin
                // undefined upper bits are returned as zero here
                cpu_rdata_d = {6'h00, col2_mem[cpu_addr_i]};
            end
            default: begin
                cpu_rdata_d = `OCAD_RST_CODE;
            end
        endcase
    end

    // read data holds until the next read
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_rdata_o  <= `OCAD_RST_CODE;
            cpu_rvalid_o <= 1'b0;
        end else begin
            cpu_rvalid_o <= cpu_rd_i;
            if (cpu_rd_i) begin
                cpu_rdata_o <= cpu_rdata_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display fetch and field decode

    wire [9:0] map_font;
    wire [3:0] map_fg;
    wire [3:0] map_bg;
    wire       map_ital;
    wire       map_flash;
    wire       map_uline;
    wire       map_aux;
    wire [3:0] map_dot;

    ocad_field_map u_map (
        .code_i           (code_mem[disp_addr_i]),
        .col1_i           (col1_mem[disp_addr_i]),
        .col2_i           (col2_mem[disp_addr_i]),
        .mode_i           (mode_i),
        .cc_range_hi_i    (cc_range_hi_i),
        .font_code_o      (map_font),
        .fg_palette_o     (map_fg),
        .bg_palette_o     (map_bg),
        .italic_o         (map_ital),
        .flash_o          (map_flash),
        .underline_o      (map_uline),
        .aux_video_gate_o (map_aux),
        .dot_palette_o    (map_dot)
    );

    // per-character dot palette kept for the dots of this character
    reg [3:0] char_dot_q;
    reg       char_cd_q;

    // decoded outputs hold until the next fetch
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_valid_o       <= 1'b0;
            font_code_o        <= `OCAD_RST_FONT;
            fg_palette_o       <= `OCAD_PAL_TRANSP;
            bg_palette_o       <= `OCAD_PAL_TRANSP;
            italic_o           <= 1'b0;
            flash_o            <= 1'b0;
            underline_o        <= 1'b0;
            aux_video_output_o <= 1'b0;
            fg_transparent_o   <= 1'b1;
            fg_black_o         <= 1'b0;
            bg_transparent_o   <= 1'b1;
            bg_black_o         <= 1'b0;
            char_dot_q         <= `OCAD_PAL_TRANSP;
            char_cd_q          <= 1'b0;
        end else begin
            disp_valid_o <= disp_req_i;
            if (disp_req_i) begin
                font_code_o        <= map_font;
                fg_palette_o       <= map_fg;
                bg_palette_o       <= map_bg;
                italic_o           <= map_ital;
                flash_o            <= map_flash;
                underline_o        <= map_uline;
                aux_video_output_o <= map_aux;
                fg_transparent_o   <= is_transp(map_fg);
                fg_black_o         <= is_black(map_fg);
                bg_transparent_o   <= is_transp(map_bg);
                bg_black_o         <= is_black(map_bg);
                char_dot_q         <= map_dot;
                char_cd_q          <= is_cd_mode(mode_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // font dot colour
    // wide cells share one attribute set per block; the display engine
    // fetches only one entry, so unequal entries would show the last one

    reg [3:0] dot_colour_d;

    always @* begin
        if (char_cd_q && is_transp(dot_palette_i)) begin
            dot_colour_d = char_dot_q;
        end else begin
            dot_colour_d = dot_palette_i;
        end
    end

    // one cycle from dot request to resolved colour
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dot_valid_o       <= 1'b0;
            dot_colour_o      <= `OCAD_PAL_TRANSP;
            dot_transparent_o <= 1'b1;
            dot_black_o       <= 1'b0;
        end else begin
            dot_valid_o <= dot_req_i;
            if (dot_req_i) begin
                dot_colour_o      <= dot_colour_d;
                dot_transparent_o <= is_transp(dot_colour_d);
                dot_black_o       <= is_black(dot_colour_d);
            end
        end
    end

endmodule // ocad_char_decode

// ### tb/ocad_chk.sv
// concurrent checks on the decoded outputs of the character entry store
// assumes: bound to ocad_char_decode; one clock, async active-low reset
`timescale 1ns/1ps
`include "ocad_map.vh"

module ocad_chk (
    // clock and reset
    input wire       ref_clk_i,
    input wire       rstn_i,
    // configuration and requests
    input wire [1:0] mode_i,
    input wire       cc_range_hi_i,
    input wire       disp_req_i,
    input wire       dot_req_i,
    input wire [3:0] dot_palette_i,
    // decoded outputs
    input wire       disp_valid_o,
    input wire [9:0] font_code_o,
    input wire [3:0] fg_palette_o,
    input wire [3:0] bg_palette_o,
    input wire       italic_o,
    input wire       flash_o,
    input wire       underline_o,
    input wire       fg_transparent_o,
    input wire       fg_black_o,
    input wire       bg_transparent_o,
    input wire       bg_black_o,
    input wire       dot_valid_o,
    input wire [3:0] dot_colour_o,
    input wire       dot_transparent_o,
    input wire       dot_black_o
);

// one domain, so clock and reset are given once
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rstn_i);

////////////////////////////////////////////////////////////////////////////////
// fetch path: mode is judged as sampled at the fetch edge
fetch_lat_a: assert property (disp_req_i |=> disp_valid_o)
    else $error("fetch answer missing");
cd_zero_a: assert property (disp_valid_o && $past(mode_i) == `OCAD_MODE_CD
    |-> font_code_o[9:7] == 3'h0 && fg_palette_o == 4'h0) else $error("colour-dot fields");
cc_range_a: assert property (disp_valid_o && $past(mode_i) == `OCAD_MODE_CC
    |-> fg_palette_o[3] == $past(cc_range_hi_i)) else $error("caption range bit");
cc_bg_a: assert property (disp_valid_o && $past(mode_i) == `OCAD_MODE_CC
    |-> bg_palette_o[3:2] == 2'h0) else $error("caption background width");
gen_fx_a: assert property (disp_valid_o && $past(mode_i[0])
    |-> !italic_o && !flash_o && !underline_o) else $error("general mode effects");
fg_flags_a: assert property (fg_transparent_o == (fg_palette_o == `OCAD_PAL_TRANSP)
    && fg_black_o == (fg_palette_o == `OCAD_PAL_BLACK)) else $error("foreground flags");
bg_flags_a: assert property (bg_transparent_o == (bg_palette_o == `OCAD_PAL_TRANSP)
    && bg_black_o == (bg_palette_o == `OCAD_PAL_BLACK)) else $error("background flags");

////////////////////////////////////////////////////////////////////////////////
// dot path: nonzero dot palettes always pass straight through
dot_lat_a: assert property (dot_req_i |=> dot_valid_o)
    else $error("dot answer missing");
dot_pass_a: assert property (dot_valid_o && $past(dot_palette_i) != 4'h0
    |-> dot_colour_o == $past(dot_palette_i)) else $error("dot palette changed");
dot_flags_a: assert property (dot_transparent_o == (dot_colour_o == `OCAD_PAL_TRANSP)
    && dot_black_o == (dot_colour_o == `OCAD_PAL_BLACK)) else $error("dot flags");

// main scenarios reached
cover property (disp_valid_o && $past(mode_i) == `OCAD_MODE_CC && italic_o);
cover property (disp_valid_o && $past(mode_i) == `OCAD_MODE_CD);
cover property (dot_valid_o && $past(dot_palette_i) == 4'h0 && dot_colour_o != 4'h0);
cover property (disp_valid_o && fg_black_o && bg_black_o);

endmodule // ocad_chk

bind ocad_char_decode ocad_chk ocad_chk_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .mode_i(mode_i), .cc_range_hi_i(cc_range_hi_i), .disp_req_i(disp_req_i),
    .dot_req_i(dot_req_i), .dot_palette_i(dot_palette_i), .disp_valid_o(disp_valid_o),
    .font_code_o(font_code_o), .fg_palette_o(fg_palette_o), .bg_palette_o(bg_palette_o),
    .italic_o(italic_o), .flash_o(flash_o), .underline_o(underline_o),
    .fg_transparent_o(fg_transparent_o), .fg_black_o(fg_black_o),
    .bg_transparent_o(bg_transparent_o), .bg_black_o(bg_black_o),
    .dot_valid_o(dot_valid_o), .dot_colour_o(dot_colour_o),
    .dot_transparent_o(dot_transparent_o), .dot_black_o(dot_black_o));

// ### tb/ocad_char_decode_bench.sv
// self-checking bench for the character entry store and decoder
// assumes: design and checker compiled first, verilog/ on the include path
`timescale 1ns/1ps
`include "ocad_map.vh"
`define CHK(n, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
    mismatches = mismatches + 1; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module ocad_char_decode_bench;
    reg        clk = 1'b0, rstn = 1'b0, range = 1'b0, wr = 1'b0, rd = 1'b0;
    reg        dreq = 1'b0, dotq = 1'b0;
    reg  [1:0] mode = 2'h0, sel = 2'h0;
    reg  [6:0] addr = 7'h00, daddr = 7'h00;
    reg  [8:0] wdata = 9'h000;
    reg  [3:0] dpal = 4'h0;
    wire [8:0] rdata;
    wire [9:0] font;
    wire [3:0] fg, bg, dcol;
    wire       rvalid, dvalid, ital, flash, ulin, aux, fgt, fgb, bgt, bgb, dotv, dott, dotb;
    int        checked = 0, mismatches = 0;

    ocad_char_decode ocad_char_decode_i (.ref_clk_i(clk), .rstn_i(rstn), .mode_i(mode),
        .cc_range_hi_i(range), .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_addr_i(addr),
        .cpu_sel_i(sel), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid),
        .disp_req_i(dreq), .disp_addr_i(daddr), .disp_valid_o(dvalid), .font_code_o(font),
        .fg_palette_o(fg), .bg_palette_o(bg), .italic_o(ital), .flash_o(flash),
        .underline_o(ulin), .aux_video_output_o(aux), .fg_transparent_o(fgt),
        .fg_black_o(fgb), .bg_transparent_o(bgt), .bg_black_o(bgb), .dot_req_i(dotq),
        .dot_palette_i(dpal), .dot_valid_o(dotv), .dot_colour_o(dcol),
        .dot_transparent_o(dott), .dot_black_o(dotb));

    // 25 MHz reference clock
    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // bus tasks: strobes are one-cycle pulses, driven 1 ns after the edge
    task wr_f(input [6:0] a, input [1:0] s, input [8:0] d);
        @(posedge clk); #1 wr = 1'b1; addr = a; sel = s; wdata = d;
        @(posedge clk); #1 wr = 1'b0;
    endtask

    // mask keeps undefined bits out of the comparison
    task rd_f(input [6:0] a, input [1:0] s, input [8:0] e, input [8:0] m);
        @(posedge clk); #1 rd = 1'b1; addr = a; sel = s;
        @(posedge clk); #1 rd = 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata & m)
    endtask

    task fetch(input [6:0] a, input [1:0] m, input r);
        @(posedge clk); #1 dreq = 1'b1; daddr = a; mode = m; range = r;
        @(posedge clk); #1 dreq = 1'b0;
        `CHK("disp_valid", 1'b1, dvalid)
    endtask

    task dot(input [3:0] p, input [3:0] e);
        @(posedge clk); #1 dotq = 1'b1; dpal = p;
        @(posedge clk); #1 dotq = 1'b0;
        `CHK("dot_valid", 1'b1, dotv)
        `CHK("dot_colour", e, dcol)
        `CHK("dot_transp", e == 4'h0, dott)
        `CHK("dot_black", e == 4'h8, dotb)
    endtask

    task fields(input [9:0] f, input [3:0] c, input [3:0] b, input [3:0] fx);
        `CHK("font", f, font)
        `CHK("fg", c, fg)
        `CHK("bg", b, bg)
        `CHK("effects", fx, {ital, flash, ulin, aux})
    endtask

    // outputs must show their reset values right after release
    task t_reset;
        `CHK("valid_rst", 3'h0, {rvalid, dvalid, dotv})
        `CHK("font_rst", 10'h000, font)
        `CHK("fg_transp_rst", 1'b1, fgt)
        `CHK("bg_transp_rst", 1'b1, bgt)
        `CHK("dot_transp_rst", 1'b1, dott)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_store;
        wr_f(7'h03, `OCAD_SEL_CODE, 9'h15a);
        wr_f(7'h03, `OCAD_SEL_COL1, 9'h0ff);
        wr_f(7'h03, `OCAD_SEL_COL2, 9'h1ff);
        wr_f(7'h03, 2'h3, 9'h123);
        rd_f(7'h03, `OCAD_SEL_CODE, 9'h15a, 9'h1ff);
        rd_f(7'h03, `OCAD_SEL_COL1, 9'h0ff, 9'h1ff);
        rd_f(7'h03, `OCAD_SEL_COL2, 9'h007, 9'h007);
    endtask

    task t_modes;
        wr_f(7'h0a, `OCAD_SEL_CODE, 9'h1a5);
        wr_f(7'h0a, `OCAD_SEL_COL1, 9'h0b5);
        wr_f(7'h0a, `OCAD_SEL_COL2, 9'h006);
        wr_f(7'h0b, `OCAD_SEL_CODE, 9'h05a);
        wr_f(7'h0b, `OCAD_SEL_COL1, 9'h04a);
        wr_f(7'h0b, `OCAD_SEL_COL2, 9'h001);
        fetch(7'h0a, `OCAD_MODE_CC, 1'b0);
        fields(10'h3a5, 4'h2, 4'h2, 4'hd);
        fetch(7'h0b, `OCAD_MODE_CC, 1'b1);
        fields(10'h05a, 4'hd, 4'h1, 4'h2);
        // both general codes decode alike
        fetch(7'h0a, `OCAD_MODE_GEN, 1'b0);
        fields(10'h3a5, 4'ha, 4'h9, 4'h1);
        fetch(7'h0a, `OCAD_MODE_GEN_ALT, 1'b1);
        fields(10'h3a5, 4'ha, 4'h9, 4'h1);
        `CHK("fg_transp", 1'b0, fgt)
    endtask

    // substitution only after a colour-dot fetch, only for palette 0
    task t_dots;
        fetch(7'h0a, `OCAD_MODE_CD, 1'b0);
        fields(10'h025, 4'h0, 4'h0, 4'h1);
        `CHK("bg_transp", 1'b1, bgt)
        dot(4'h0, 4'h6);
        dot(4'h5, 4'h5);
        dot(4'h8, 4'h8);
        fetch(7'h0b, `OCAD_MODE_CC, 1'b0);
        dot(4'h0, 4'h0);
    endtask

    // a wide-cell pair sharing colour code 1 but not colour code 2, both palettes black
    task t_black_wide;
        wr_f(7'h0c, `OCAD_SEL_COL1, 9'h090);
        wr_f(7'h0d, `OCAD_SEL_COL1, 9'h090);
        wr_f(7'h0c, `OCAD_SEL_COL2, 9'h002);
        fetch(7'h0c, `OCAD_MODE_GEN, 1'b0);
        fields(10'h000, 4'h8, 4'h8, 4'h1);
        `CHK("fg_black", 1'b1, fgb)
        `CHK("bg_black", 1'b1, bgb)
        `CHK("bg_transp", 1'b0, bgt)
        fetch(7'h0d, `OCAD_MODE_CD, 1'b0);
        fields(10'h000, 4'h0, 4'h0, 4'h1);
        dot(4'h0, 4'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard
    initial begin
        #800000;
        mismatches = mismatches + 1;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        t_reset;
        t_store;
        t_modes;
        t_dots;
        t_black_wide;
        stop_test;
    end
endmodule // ocad_char_decode_bench
